// file: design/field_decoder_pkg.sv
// Constants and carrier types for the continuable field decoder.
// Assumes a single clock domain; the byte source and result consumer are plain logic.
//
// Overview of operation
// RULE1 - Plain fields take bytes little-endian; first byte fills the lowest eight bits.
// RULE2 - Unsigned continuable fields start from an all-zero value.
// RULE3 - Replacement fields start from a supplied value; only covered low bits change.
// RULE4 - Each continuation byte writes its low seven bits at the position, then advances seven.
// RULE5 - Continuation ends on a byte with bit 7 clear, or position at least N-8.
// RULE6 - If the last continuation byte had bit 7 set, one full byte follows.
// RULE7 - A full byte crossing the top must have bits end..7 zero; end is N mod 7 or 7.
// RULE8 - Any non-zero bit found by the must-be-zero check raises a decode error.
// RULE9 - A completed field gives a one-cycle valid pulse; the error flag sticks until reset.
package field_decoder_pkg;

	// ----------------------------------------------------------------
	// Field geometry
	// ----------------------------------------------------------------
	localparam int BYTE_W = 8;
	localparam int CONT_BIT = 7;
	localparam int CONT_STEP = 7;
	localparam int MAX_N = 64;
	localparam int POS_W = 7;
	localparam int FIFO_DEPTH = 16;

	// ----------------------------------------------------------------
	// Modes and states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_PLAIN = 2'h0,
		MODE_UNSIGNED = 2'h1,
		MODE_REPLACE = 2'h2
	} field_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONT = 2'b01,
		ST_FULL = 2'b11,
		ST_PLAIN = 2'b10
	} dec_state_t;

	typedef struct packed {
		field_mode_t mode;
		logic [POS_W-1:0] width;
		logic [MAX_N-1:0] original;
	} field_req_t;

	typedef struct packed {
		logic [MAX_N-1:0] value;
		logic error;
	} field_res_t;

endpackage : field_decoder_pkg

// file: design/byte_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic push;
	logic pop;

	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	// Ready is registered from the next count so the port comes from a flop
	always_ff @(posedge clk) begin
		if (rst) begin
			in_ready <= 1'b1;
		end else begin
			in_ready <= (cnt_d != (AW+1)'(DEPTH));
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
		end
	end

endmodule : byte_fifo

// file: design/continuable_field_decoder.sv
// Decodes plain and continuable fields from a trace byte stream.
// Assumes the byte source honours byte_ready and a request is held until req_ready.
`timescale 1ns/1ps
module continuable_field_decoder
	import field_decoder_pkg::*;
#(
	parameter int N_MAX = MAX_N,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [BYTE_W-1:0] byte_data,
	input wire logic byte_valid,
	output logic byte_ready,
	input wire field_req_t req,
	input wire logic req_valid,
	output logic req_ready,
	output field_res_t res,
	output logic res_valid,
	output logic error_flag
);
	// ----------------------------------------------------------------
	// Input buffering
	// ----------------------------------------------------------------
	logic [BYTE_W-1:0] fb_data;
	logic fb_valid;
	logic fb_ready;

	byte_fifo #(
		.WIDTH(BYTE_W),
		.DEPTH(DEPTH)
	) i_byte_fifo (
		.clk(clk),
		.rst(rst),
		.in_data(byte_data),
		.in_valid(byte_valid),
		.in_ready(byte_ready),
		.out_data(fb_data),
		.out_valid(fb_valid),
		.out_ready(fb_ready)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Writes the low len bits of a byte at pos, leaving other bits alone.
	function automatic logic [MAX_N-1:0] put_bits(input logic [MAX_N-1:0] r,
			input logic [BYTE_W-1:0] b, input logic [POS_W-1:0] pos,
			input int len);
		logic [MAX_N-1:0] m;
		logic [MAX_N-1:0] v;
		m = (MAX_N'(1) << len) - MAX_N'(1);
		v = MAX_N'(b) & m;
		put_bits = (r & ~(m << pos)) | (v << pos);
	endfunction : put_bits

	// Keeps only bits below width.
	function automatic logic [MAX_N-1:0] trim(input logic [MAX_N-1:0] r,
			input logic [POS_W-1:0] w);
		trim = (w >= POS_W'(MAX_N)) ? r : (r & ((MAX_N'(1) << w) - MAX_N'(1)));
	endfunction : trim

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	dec_state_t state_q;
	logic [MAX_N-1:0] acc_q;
	logic [POS_W-1:0] pos_q;
	logic [POS_W-1:0] width_q;
	logic take;
	logic [POS_W-1:0] end_bit;
	logic sbz_bad;
	logic [BYTE_W-1:0] sbz_mask;

	// Registered ready: drops on the taking edge, stays low through the result pulse
	always_ff @(posedge clk) begin
		if (rst) begin
			req_ready <= 1'b1;
		end else begin
			req_ready <= (state_q == ST_IDLE) && !(req_valid && req_ready);
		end
	end
	assign fb_ready = (state_q != ST_IDLE);
	assign take = fb_valid && fb_ready; // stream_byte_take

	// End of the legal part of the final byte
	always_comb begin
		end_bit = POS_W'(width_q % CONT_STEP); // see RULE7
		if (end_bit == '0) begin
			end_bit = POS_W'(CONT_STEP);
		end
		sbz_mask = BYTE_W'(8'hFF << end_bit);
		sbz_bad = ((pos_q + POS_W'(BYTE_W)) > width_q) &&
			((fb_data & sbz_mask) != '0); // must_be_zero_check, see RULE7
	end

	// ----------------------------------------------------------------
	// Decode sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			acc_q <= '0;
			pos_q <= '0;
			width_q <= '0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (req_valid && req_ready) begin
						width_q <= req.width;
						pos_q <= '0;
						if (req.mode == MODE_REPLACE) begin
							acc_q <= req.original; // see RULE3
						end else begin
							acc_q <= '0; // see RULE2
						end
						if (req.mode == MODE_PLAIN) begin
							state_q <= ST_PLAIN;
						end else begin
							state_q <= ST_CONT;
						end
					end
				end
				ST_PLAIN: begin
					if (take) begin
						// plain_little_endian_field: first byte lowest
						acc_q <= put_bits(acc_q, fb_data, pos_q, BYTE_W); // see RULE1
						pos_q <= pos_q + POS_W'(BYTE_W);
						if ((pos_q + POS_W'(BYTE_W)) >= width_q) begin
							state_q <= ST_IDLE;
						end
					end
				end
				ST_CONT: begin
					if (take) begin
						// replacement_field_decode step
						acc_q <= put_bits(acc_q, fb_data, pos_q, CONT_STEP); // see RULE4
						pos_q <= pos_q + POS_W'(CONT_STEP); // see RULE4
						if (!fb_data[CONT_BIT]) begin
							state_q <= ST_IDLE; // see RULE5
						end else if ((pos_q + POS_W'(CONT_STEP) + POS_W'(BYTE_W)) >=
								width_q) begin
							state_q <= ST_FULL; // see RULE5, RULE6
						end
					end
				end
				ST_FULL: begin
					if (take) begin
						acc_q <= put_bits(acc_q, fb_data, pos_q, BYTE_W); // see RULE6
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Result and error
	// ----------------------------------------------------------------
	logic done;
	logic fin_plain;
	logic fin_cont;

	assign fin_plain = (state_q == ST_PLAIN) && take &&
		((pos_q + POS_W'(BYTE_W)) >= width_q);
	assign fin_cont = (state_q == ST_CONT) && take && !fb_data[CONT_BIT];
	assign done = fin_plain || fin_cont || ((state_q == ST_FULL) && take);

	always_ff @(posedge clk) begin
		if (rst) begin
			res_valid <= 1'b0;
			res <= '0;
		end else begin
			res_valid <= done; // see RULE9
			if (done) begin
				if (state_q == ST_FULL) begin
					res.value <= trim(put_bits(acc_q, fb_data, pos_q, BYTE_W), width_q);
				end else if (state_q == ST_PLAIN) begin
					res.value <= trim(put_bits(acc_q, fb_data, pos_q, BYTE_W), width_q);
				end else begin
					res.value <= trim(put_bits(acc_q, fb_data, pos_q, CONT_STEP), width_q);
				end
				res.error <= (state_q == ST_FULL) && sbz_bad;
			end
		end
	end

	// Sticky until reset; no clear path exists
	always_ff @(posedge clk) begin
		if (rst) begin
			error_flag <= 1'b0;
		end else if ((state_q == ST_FULL) && take && sbz_bad) begin
			error_flag <= 1'b1; // see RULE8, RULE9
		end
	end

endmodule : continuable_field_decoder

// file: test/field_decoder_props.sv
// Checker for the decoder's result handshake, masking and error flag.
// Assumes one clock with synchronous active-high reset.
`timescale 1ns/1ps
module field_decoder_props
	import field_decoder_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire field_req_t req,
	input wire field_res_t res,
	input wire logic res_valid,
	input wire logic error_flag
);
	logic [POS_W-1:0] w_q;
	always_ff @(posedge clk) begin
		if (req_valid && req_ready) begin
			w_q <= req.width;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_taken;
		req_valid && req_ready;
	endsequence
	sequence s_done;
		res_valid ##1 !res_valid;
	endsequence
	a_pulse_once: assert property (res_valid |=> !res_valid)
		else $error("result valid too long");
	a_err_sticky: assert property (error_flag |=> error_flag)
		else $error("error flag dropped");
	a_err_flagged: assert property (res_valid && res.error |=> error_flag)
		else $error("field error not flagged");
	a_busy_refuse: assert property (res_valid |-> !req_ready)
		else $error("request accepted in result cycle");
	a_taken_busy: assert property (s_taken |=> !req_ready)
		else $error("request accepted while decoding");
	a_ready_after: assert property (s_done |-> req_ready)
		else $error("not ready after result");
	a_value_masked: assert property (res_valid && w_q < 7'h40 |-> (res.value >> w_q) == '0)
		else $error("bits above width set");
	a_res_hold: assert property (!$stable(res) |-> res_valid)
		else $error("result changed without valid");
endmodule : field_decoder_props
bind continuable_field_decoder field_decoder_props i_field_decoder_props (.clk(clk), .rst(rst),
	.req_valid(req_valid), .req_ready(req_ready), .req(req), .res(res),
	.res_valid(res_valid), .error_flag(error_flag));

// file: test/byte_source.sv
// Model of the trace byte source feeding the decoder.
// Assumes bytes are queued by the bench through put.
`timescale 1ns/1ps
module byte_source (
	input wire logic clk,
	input wire logic slow,
	input wire logic byte_ready,
	output logic [7:0] byte_data,
	output logic byte_valid
);
	logic [7:0] q[$];
	logic hs = 1'b0;
	logic gap = 1'b0;
	task automatic put(input logic [7:0] v);
		q.push_back(v);
	endtask : put
	initial begin
		byte_valid = 1'b0;
		byte_data = 8'h00;
	end
	// Offer held until taken; idle line shows a changing pattern, not the old byte
	always @(negedge clk) begin
		if (hs) void'(q.pop_front());
		if (!byte_valid || hs) begin
			gap = slow && !gap;
			byte_valid = !gap && q.size() > 0;
			byte_data = byte_valid ? q[0] : ~byte_data;
		end
		hs = byte_valid && byte_ready;
	end
endmodule : byte_source

// file: test/tb.sv
// Self-checking bench for the continuable field decoder.
// Assumes the byte source model and the bound checker.
`timescale 1ns/1ps
module tb;
	import field_decoder_pkg::*;
	logic clk, rst, byte_valid, byte_ready, req_valid, req_ready, res_valid, error_flag, slow;
	logic [7:0] byte_data;
	logic [7:0] b[10];
	logic [31:0] seed = 32'h33;
	logic any_err;
	logic [63:0] orig;
	field_req_t req;
	field_res_t res;
	field_res_t exp_q[$];
	field_mode_t m;
	int bad_count, check_count, cyc, n, w;
	continuable_field_decoder i_continuable_field_decoder (.clk(clk), .rst(rst),
		.byte_data(byte_data), .byte_valid(byte_valid), .byte_ready(byte_ready), .req(req),
		.req_valid(req_valid), .req_ready(req_ready), .res(res), .res_valid(res_valid),
		.error_flag(error_flag));
	byte_source i_byte_source (.clk(clk), .slow(slow), .byte_ready(byte_ready),
		.byte_data(byte_data), .byte_valid(byte_valid));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	task automatic check(input logic [64:0] seen, input logic [64:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	// Independent model of the field decode, also telling how many bytes it eats
	function automatic field_res_t ref_dec(logic [63:0] o);
		field_res_t r;
		logic [7:0] x;
		int i, e;
		r.value = (m == MODE_REPLACE) ? o : 64'h0;
		r.error = 1'b0;
		i = 0;
		n = 0;
		if (m == MODE_PLAIN) begin
			n = (w + 7) / 8;
			for (int k = 0; k < n; k++) r.value[8*k+:8] = b[k];
		end else begin
			do begin
				x = b[n++];
				for (int k = 0; k < 7; k++) if (i + k < 64) r.value[i+k] = x[k];
				i += 7;
			end while (x[7] && i < w - 8);
			if (x[7]) begin
				x = b[n++];
				for (int k = 0; k < 8; k++) if (i + k < 64) r.value[i+k] = x[k];
				e = (w % 7 == 0) ? 7 : w % 7;
				if (i + 8 > w) for (int k = e; k < 8; k++) if (x[k]) r.error = 1'b1;
			end
		end
		if (w < 64) r.value &= (64'h1 << w) - 64'h1;
		return r;
	endfunction : ref_dec
	task automatic prep(input logic [63:0] o);
		field_res_t r;
		for (int k = 0; k < 10; k++) b[k] = rnd();
		r = ref_dec(o);
		for (int k = 0; k < n; k++) i_byte_source.put(b[k]);
		exp_q.push_back(r);
		any_err |= r.error;
	endtask : prep
	task automatic issue(input logic [63:0] o);
		req = '{m, 7'(w), o};
		req_valid = 1'b1;
		while (!req_ready) @(negedge clk);
		@(negedge clk);
		req_valid = 1'b0;
		@(negedge clk);
	endtask : issue
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			end_sim();
		end
	end
	always @(negedge clk) begin
		if (!rst && res_valid) check(res, exp_q.size() ? exp_q.pop_front() : 'x);
	end
	initial begin
		rst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		slow = 1'b0;
		any_err = 1'b0;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		m = MODE_PLAIN;
		w = 64;
		prep(64'h0);
		prep(64'h0);
		w = 8;
		prep(64'h0);
		repeat (30) @(negedge clk);
		check({64'h0, byte_ready}, 65'h0);
		w = 64;
		issue(64'h0);
		issue(64'h0);
		w = 8;
		issue(64'h0);
		for (int i = 0; i < 90; i++) begin
			m = field_mode_t'(i % 3);
			w = 8 + rnd() % 57;
			slow = rnd() % 2;
			orig = {rnd(), rnd()};
			prep(orig);
			issue(orig);
		end
		for (int t = 0; t < 200 && exp_q.size() > 0; t++) @(negedge clk);
		check(65'(exp_q.size()), 65'h0);
		check({64'h0, error_flag}, {64'h0, any_err});
		end_sim();
	end
endmodule : tb
